// >>> msc_pkg.sv
/*
  msc_pkg: constants, encodings and the state record of the module
  stop and sleep control block.
  assumes: one 125 MHz system clock, AXI4-Lite register access with
  8-bit byte addresses and 32-bit data.
*/
`default_nettype none
package msc_pkg;
  localparam int MSC_ADDR_W = 8;
  localparam int MSC_DATA_W = 32;
  localparam int MSC_STOP_W = 6;
  localparam int MSC_LEVEL_W = 4;
  // register byte offsets
  localparam logic [7:0] MSC_OFS_STOP = 8'h00;
  localparam logic [7:0] MSC_OFS_PDC1 = 8'h04;
  localparam logic [7:0] MSC_OFS_STAT = 8'h08;
  // module clock stop register fields
  localparam int MSC_BIT_PULSE_TIMER = 5;
  localparam int MSC_BIT_SYNC_CH2 = 4;
  localparam int MSC_BIT_SYNC_CH1 = 3;
  localparam int MSC_BIT_FIFO_SERIAL = 2;
  localparam int MSC_BIT_UART_CH2 = 1;
  localparam int MSC_BIT_UART_CH1 = 0;
  localparam logic [7:0] MSC_STOP_MASK = 8'h3F;
  localparam logic [7:0] MSC_STOP_RESET = 8'h00;
  // power-down control one field
  localparam int MSC_BIT_STANDBY_SELECT = 7;
  localparam logic MSC_STANDBY_RESET = 1'b0;
  // status register fields
  localparam int MSC_BIT_STAT_ASLEEP = 0;
  localparam int MSC_BIT_STAT_WOKE_IRQ = 1;
  localparam int MSC_BIT_STAT_WOKE_DMA = 2;
  // bus responses
  localparam logic [1:0] MSC_RESP_OKAY = 2'h0;
  localparam logic [1:0] MSC_RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {MSC_RUN, MSC_SLEEP} msc_power_t;
  typedef enum logic [1:0] {MSC_SEL_STOP, MSC_SEL_PDC1, MSC_SEL_STAT, MSC_SEL_NONE} msc_sel_t;

  typedef struct packed {
    logic [MSC_STOP_W-1:0] stop;
    logic standby_select;
    msc_power_t power;
    logic woke_irq;
    logic woke_dma;
    logic [MSC_STOP_W-1:0] clk_en;
    logic wake_irq_start;
    logic wake_dma_start;
    logic standby_req;
    logic aw_got;
    logic [MSC_ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [MSC_DATA_W-1:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [MSC_DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } msc_state_t;
endpackage
`default_nettype wire

// >>> msc_module_stop_sleep.sv
/*
  msc_module_stop_sleep: module clock stop register with per-module
  clock enables, and the sleep mode controller, behind an AXI4-Lite slave.
  assumes: all inputs synchronous to clk_sys; the cpu raises sleep_exec
  for one cycle per sleep instruction; gated modules use the clk_en
  outputs as clock enables and the init outputs as synchronous clears.
*/
`timescale 1ns/10ps
`default_nettype none
module msc_module_stop_sleep
  import msc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic manual_rst,
  input wire logic [MSC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [MSC_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [MSC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [MSC_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sleep_exec,
  input wire logic irq_req,
  input wire logic [MSC_LEVEL_W-1:0] irq_level,
  input wire logic [MSC_LEVEL_W-1:0] sr_mask,
  input wire logic irq_src_enabled,
  input wire logic dma_addr_error,
  output logic cpu_halt,
  output logic wake_irq_start,
  output logic wake_dma_err_start,
  output logic standby_req,
  output logic pulse_timer_clk_en,
  output logic sync_serial_ch2_clk_en,
  output logic sync_serial_ch1_clk_en,
  output logic fifo_serial_clk_en,
  output logic uart_ch2_clk_en,
  output logic uart_ch1_clk_en,
  output logic uart_ch2_init,
  output logic uart_ch1_init,
  output logic [MSC_STOP_W-1:0] interrupt_controller_vector_keep
);

  // one decoder serves both the write and the read path
  function automatic msc_sel_t decode(input logic [MSC_ADDR_W-1:0] addr);
    msc_sel_t sel;
    sel = MSC_SEL_NONE;
    if (addr[1:0] == 2'h0)
    begin
      if (addr == MSC_OFS_STOP)
      begin
        sel = MSC_SEL_STOP;
      end
      else if (addr == MSC_OFS_PDC1)
      begin
        sel = MSC_SEL_PDC1;
      end
      else if (addr == MSC_OFS_STAT)
      begin
        sel = MSC_SEL_STAT;
      end
    end
    return sel;
  endfunction

  msc_state_t state;
  msc_state_t next_state;

  logic aw_take;
  logic w_take;
  logic ar_take;
  logic do_write;
  logic irq_accepted;
  msc_sel_t wr_sel;
  msc_sel_t rd_sel;
  logic [7:0] stop_view;
  logic [7:0] pdc1_view;
  logic [7:0] stat_view;

  assign s_axi_awready = !state.aw_got && !state.bvalid;
  assign s_axi_wready = !state.w_got && !state.bvalid;
  assign s_axi_arready = !state.rvalid;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  // address and data may arrive in either order; write once both held
  assign do_write = state.aw_got && state.w_got && !state.bvalid;
  assign wr_sel = decode(state.aw_addr);
  assign rd_sel = decode(s_axi_araddr);

  // priority above mask and enabled at the source, else no wake
  assign irq_accepted = irq_req && irq_src_enabled && (irq_level > sr_mask);

  always_comb
  begin
    stop_view = MSC_STOP_MASK & {2'h0, state.stop};
    pdc1_view = 8'h00;
    pdc1_view[MSC_BIT_STANDBY_SELECT] = state.standby_select;
    stat_view = 8'h00;
    stat_view[MSC_BIT_STAT_ASLEEP] = (state.power == MSC_SLEEP);
    stat_view[MSC_BIT_STAT_WOKE_IRQ] = state.woke_irq;
    stat_view[MSC_BIT_STAT_WOKE_DMA] = state.woke_dma;
  end

  always_comb
  begin
    next_state = state;
    next_state.wake_irq_start = 1'b0;
    next_state.wake_dma_start = 1'b0;
    next_state.standby_req = 1'b0;

    // write channel capture
    if (aw_take)
    begin
      next_state.aw_got = 1'b1;
      next_state.aw_addr = s_axi_awaddr;
    end
    if (w_take)
    begin
      next_state.w_got = 1'b1;
      next_state.w_data = s_axi_wdata;
      next_state.w_lane0 = s_axi_wstrb[0];
    end
    if (do_write)
    begin
      next_state.aw_got = 1'b0;
      next_state.w_got = 1'b0;
      next_state.bvalid = 1'b1;
      next_state.bresp = MSC_RESP_OKAY;
      // all fields live in byte lane 0; other lanes are ignored
      unique case (wr_sel)
        MSC_SEL_STOP:
        begin
          if (state.w_lane0)
          begin
            next_state.stop = state.w_data[MSC_STOP_W-1:0];
          end
        end
        MSC_SEL_PDC1:
        begin
          if (state.w_lane0)
          begin
            next_state.standby_select = state.w_data[MSC_BIT_STANDBY_SELECT];
          end
        end
        MSC_SEL_STAT:
        begin
          next_state.bresp = MSC_RESP_OKAY;
        end
        MSC_SEL_NONE:
        begin
          next_state.bresp = MSC_RESP_SLVERR;
        end
      endcase
    end
    if (state.bvalid && s_axi_bready)
    begin
      next_state.bvalid = 1'b0;
    end

    // read channel
    if (state.rvalid && s_axi_rready)
    begin
      next_state.rvalid = 1'b0;
    end
    if (ar_take)
    begin
      next_state.rvalid = 1'b1;
      next_state.rresp = MSC_RESP_OKAY;
      unique case (rd_sel)
        MSC_SEL_STOP:
        begin
          next_state.rdata = {24'h000000, stop_view};
        end
        MSC_SEL_PDC1:
        begin
          next_state.rdata = {24'h000000, pdc1_view};
        end
        MSC_SEL_STAT:
        begin
          next_state.rdata = {24'h000000, stat_view};
        end
        MSC_SEL_NONE:
        begin
          next_state.rdata = '0;
          next_state.rresp = MSC_RESP_SLVERR;
        end
      endcase
    end

    // enables follow the stop bits one edge late, so each gate flips
    // between edges and never clips a pulse; sleep does not touch them
    next_state.clk_en = ~state.stop;

    // sleep controller
    unique case (state.power)
      MSC_RUN:
      begin
        if (sleep_exec)
        begin
          if (state.standby_select)
          begin
            next_state.standby_req = 1'b1;
          end
          else
          begin
            next_state.power = MSC_SLEEP;
            next_state.woke_irq = 1'b0;
            next_state.woke_dma = 1'b0;
          end
        end
      end
      MSC_SLEEP:
      begin
        // address error outranks an interrupt arriving in the same cycle
        if (dma_addr_error)
        begin
          next_state.power = MSC_RUN;
          next_state.wake_dma_start = 1'b1;
          next_state.woke_dma = 1'b1;
        end
        else if (irq_accepted)
        begin
          next_state.power = MSC_RUN;
          next_state.wake_irq_start = 1'b1;
          next_state.woke_irq = 1'b1;
        end
      end
    endcase
  end

  // both resets cancel sleep and clear the registers
  always_ff @(posedge clk_sys)
  begin
    if (rst || manual_rst)
    begin
      state <= '0;
      state.stop <= MSC_STOP_RESET[MSC_STOP_W-1:0];
      state.standby_select <= MSC_STANDBY_RESET;
      state.power <= MSC_RUN;
      state.clk_en <= '1;
      state.bresp <= MSC_RESP_OKAY;
      state.rresp <= MSC_RESP_OKAY;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign s_axi_bvalid = state.bvalid;
  assign s_axi_bresp = state.bresp;
  assign s_axi_rvalid = state.rvalid;
  assign s_axi_rdata = state.rdata;
  assign s_axi_rresp = state.rresp;

  // cpu stops on the edge after sleep_exec, its registers untouched: only the clock halts
  assign cpu_halt = (state.power == MSC_SLEEP);
  assign wake_irq_start = state.wake_irq_start;
  assign wake_dma_err_start = state.wake_dma_start;
  assign standby_req = state.standby_req;

  // retaining modules just lose their enable and resume where they were
  assign pulse_timer_clk_en = state.clk_en[MSC_BIT_PULSE_TIMER];
  assign sync_serial_ch2_clk_en = state.clk_en[MSC_BIT_SYNC_CH2];
  assign sync_serial_ch1_clk_en = state.clk_en[MSC_BIT_SYNC_CH1];
  assign fifo_serial_clk_en = state.clk_en[MSC_BIT_FIFO_SERIAL];
  assign uart_ch2_clk_en = state.clk_en[MSC_BIT_UART_CH2];
  assign uart_ch1_clk_en = state.clk_en[MSC_BIT_UART_CH1];

  // uarts held in clear for the whole stop, so they restart from reset
  assign uart_ch2_init = !state.clk_en[MSC_BIT_UART_CH2];
  assign uart_ch1_init = !state.clk_en[MSC_BIT_UART_CH1];

  // vector registers must not see the uart clear
  assign interrupt_controller_vector_keep = ~state.clk_en;

endmodule
`default_nettype wire

// >>> msc_sleep_props.sv
/* msc_sleep_props: bus, clock gate and sleep checks for the stop/sleep block.
   assumes: bound to msc_module_stop_sleep, one clk_sys domain. */
`timescale 1ns/10ps
`default_nettype none
module msc_sleep_props
  import msc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic manual_rst,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [MSC_DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sleep_exec,
  input wire logic irq_req,
  input wire logic [MSC_LEVEL_W-1:0] irq_level,
  input wire logic [MSC_LEVEL_W-1:0] sr_mask,
  input wire logic irq_src_enabled,
  input wire logic dma_addr_error,
  input wire logic cpu_halt,
  input wire logic wake_irq_start,
  input wire logic wake_dma_err_start,
  input wire logic standby_req,
  input wire logic pulse_timer_clk_en
);
  // wake only above the mask and enabled at source
  wire logic irq_ok = irq_req && irq_src_enabled && (irq_level > sr_mask);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst || manual_rst);
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  sleep_entry_a: assert property (sleep_exec && !cpu_halt |=> cpu_halt != standby_req)
    else $error("sleep instruction ignored");
  halt_cause_a: assert property ($rose(cpu_halt) |-> $past(sleep_exec))
    else $error("halt without sleep");
  low_irq_a: assert property (cpu_halt && !dma_addr_error && !irq_ok |=> cpu_halt)
    else $error("woke without cause");
  irq_wake_a: assert property (cpu_halt && !dma_addr_error && irq_ok |=> !cpu_halt && wake_irq_start)
    else $error("irq did not wake");
  dma_wake_a: assert property (cpu_halt && dma_addr_error |=> !cpu_halt && wake_dma_err_start && !wake_irq_start)
    else $error("dma error did not wake");
  gate_edge_a: assert property ($changed(pulse_timer_clk_en) && !$past(rst) && !$past(manual_rst)
    |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
    else $error("gate moved off write");
endmodule
bind msc_module_stop_sleep msc_sleep_props u_props (.clk_sys, .rst, .manual_rst, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .sleep_exec, .irq_req, .irq_level, .sr_mask,
  .irq_src_enabled, .dma_addr_error, .cpu_halt, .wake_irq_start, .wake_dma_err_start, .standby_req,
  .pulse_timer_clk_en);
`default_nettype wire

// >>> msc_testbench.sv
/* testbench: register, clock stop and sleep scenarios for the stop/sleep block.
   assumes: msc_pkg and the checker are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module testbench
  import msc_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic manual_rst = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sleep_exec = 1'b0, irq_req = 1'b0;
  logic irq_src_enabled = 1'b0, dma_addr_error = 1'b0;
  logic [MSC_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [MSC_DATA_W-1:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [MSC_LEVEL_W-1:0] irq_level = 4'h0, sr_mask = 4'h5;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_halt, wake_irq_start;
  logic wake_dma_err_start, standby_req, pulse_timer_clk_en, sync_serial_ch2_clk_en, sync_serial_ch1_clk_en;
  logic fifo_serial_clk_en, uart_ch2_clk_en, uart_ch1_clk_en, uart_ch2_init, uart_ch1_init;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [MSC_DATA_W-1:0] s_axi_rdata, rd;
  logic [MSC_STOP_W-1:0] interrupt_controller_vector_keep;
  wire logic [5:0] clk_ens = {pulse_timer_clk_en, sync_serial_ch2_clk_en, sync_serial_ch1_clk_en,
    fifo_serial_clk_en, uart_ch2_clk_en, uart_ch1_clk_en};
  int fails = 0, samples_checked = 0;
  always #4 clk_sys = ~clk_sys;
  msc_module_stop_sleep uut (.clk_sys, .rst, .manual_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sleep_exec, .irq_req, .irq_level, .sr_mask, .irq_src_enabled, .dma_addr_error, .cpu_halt, .wake_irq_start,
    .wake_dma_err_start, .standby_req, .pulse_timer_clk_en, .sync_serial_ch2_clk_en, .sync_serial_ch1_clk_en,
    .fifo_serial_clk_en, .uart_ch2_clk_en, .uart_ch1_clk_en, .uart_ch2_init, .uart_ch1_init, .interrupt_controller_vector_keep);
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic timed_out(input int n);
    if (n >= 40)
    begin
      fails++;
      give_verdict();
    end
  endtask
  // handshakes are judged mid-cycle, where ready and valid are settled
  task automatic wr_check(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    logic aw_ok, w_ok, b_ok;
    logic [1:0] resp;
    n = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    b_ok = 1'b0;
    resp = 2'h0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b_ok && n < 40)
    begin
      @(negedge clk_sys);
      n++;
      aw_ok = s_axi_awvalid && s_axi_awready;
      w_ok = s_axi_wvalid && s_axi_wready;
      b_ok = s_axi_bvalid && s_axi_bready;
      resp = s_axi_bresp;
      @(posedge clk_sys);
      if (aw_ok)
      begin
        s_axi_awvalid <= 1'b0;
      end
      if (w_ok)
      begin
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b0;
    timed_out(b_ok ? 0 : 40);
    check("write resp", 32'(er), 32'(resp));
    #1;
  endtask
  task automatic rd_check(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    logic ar_ok, r_ok;
    logic [31:0] data;
    logic [1:0] resp;
    n = 0;
    ar_ok = 1'b0;
    r_ok = 1'b0;
    data = 32'h00000000;
    resp = 2'h0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r_ok && n < 40)
    begin
      @(negedge clk_sys);
      n++;
      ar_ok = s_axi_arvalid && s_axi_arready;
      r_ok = s_axi_rvalid && s_axi_rready;
      data = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk_sys);
      if (ar_ok)
      begin
        s_axi_arvalid <= 1'b0;
      end
    end
    s_axi_rready <= 1'b0;
    timed_out(r_ok ? 0 : 40);
    check("read data", exp, data);
    check("read resp", 32'(er), 32'(resp));
    #1;
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic go_sleep;
    @(posedge clk_sys);
    sleep_exec <= 1'b1;
    @(posedge clk_sys);
    sleep_exec <= 1'b0;
    #1;
  endtask
  task automatic t_registers;
    rd_check(MSC_OFS_STOP, 32'h0, MSC_RESP_OKAY);
    for (int i = 0; i < 6; i++)
    begin
      wr_check(MSC_OFS_STOP, 8'h01 << i, MSC_RESP_OKAY);
      check("clock enables", 32'(6'(~(6'h01 << i))), 32'(clk_ens));
      check("uart init", 32'((6'h01 << i) & 6'h03), 32'({uart_ch2_init, uart_ch1_init}));
      check("vector keep", 32'(6'h01 << i), 32'(interrupt_controller_vector_keep));
    end
    wr_check(MSC_OFS_STOP, 8'hFF, MSC_RESP_OKAY);
    rd_check(MSC_OFS_STOP, 32'h3F, MSC_RESP_OKAY);
    wr_check(8'h0C, 8'h00, MSC_RESP_SLVERR);
    rd_check(8'h0C, 32'h0, MSC_RESP_SLVERR);
    wr_check(MSC_OFS_STAT, 8'hFF, MSC_RESP_OKAY);
    rd_check(MSC_OFS_STAT, 32'h0, MSC_RESP_OKAY);
    wr_check(MSC_OFS_STOP, 8'h00, MSC_RESP_OKAY);
    check("clock enables", 32'h3F, 32'(clk_ens));
  endtask
  task automatic t_sleep;
    go_sleep();
    check("halt", 32'h1, 32'(cpu_halt));
    check("clock enables", 32'h3F, 32'(clk_ens));
    rd_check(MSC_OFS_STAT, 32'h1, MSC_RESP_OKAY);
    // equal level must not wake, then a disabled source must not either
    @(posedge clk_sys);
    irq_req <= 1'b1;
    irq_level <= 4'h5;
    irq_src_enabled <= 1'b1;
    step(3);
    check("halt", 32'h1, 32'(cpu_halt));
    @(posedge clk_sys);
    irq_level <= 4'h6;
    irq_src_enabled <= 1'b0;
    step(3);
    check("halt", 32'h1, 32'(cpu_halt));
    @(posedge clk_sys);
    irq_src_enabled <= 1'b1;
    step(1);
    check("irq start", 32'h1, 32'(wake_irq_start));
    check("halt", 32'h0, 32'(cpu_halt));
    @(posedge clk_sys);
    irq_req <= 1'b0;
    rd_check(MSC_OFS_STAT, 32'h2, MSC_RESP_OKAY);
    go_sleep();
    @(posedge clk_sys);
    dma_addr_error <= 1'b1;
    irq_req <= 1'b1;
    step(1);
    check("dma start", 32'h1, 32'(wake_dma_err_start));
    check("irq start", 32'h0, 32'(wake_irq_start));
    check("halt", 32'h0, 32'(cpu_halt));
    @(posedge clk_sys);
    dma_addr_error <= 1'b0;
    irq_req <= 1'b0;
    rd_check(MSC_OFS_STAT, 32'h4, MSC_RESP_OKAY);
  endtask
  task automatic t_standby;
    wr_check(MSC_OFS_PDC1, 8'h80, MSC_RESP_OKAY);
    rd_check(MSC_OFS_PDC1, 32'h80, MSC_RESP_OKAY);
    go_sleep();
    check("standby", 32'h1, 32'(standby_req));
    check("halt", 32'h0, 32'(cpu_halt));
    wr_check(MSC_OFS_PDC1, 8'h00, MSC_RESP_OKAY);
  endtask
  task automatic t_resets;
    wr_check(MSC_OFS_STOP, 8'h15, MSC_RESP_OKAY);
    go_sleep();
    @(posedge clk_sys);
    manual_rst <= 1'b1;
    @(posedge clk_sys);
    manual_rst <= 1'b0;
    #1;
    check("halt", 32'h0, 32'(cpu_halt));
    check("clock enables", 32'h3F, 32'(clk_ens));
    rd_check(MSC_OFS_STOP, 32'h0, MSC_RESP_OKAY);
    go_sleep();
    @(posedge clk_sys);
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    check("halt", 32'h0, 32'(cpu_halt));
  endtask
  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    t_registers();
    t_sleep();
    t_standby();
    t_resets();
    give_verdict();
  end
endmodule
`default_nettype wire
